// *** emb_bus.sv ***
// External memory bus pin sequencer: address, shared lines, latch strobe
`timescale 1ns/1ps
// Contract
// - Low address lines hold bits 0-15 all cycle; released in read sync cycles
// - Upper lines hold bits 16-19 all cycle; released in read sync cycles
// - Internal 24-bit address, only low 20 out
// - First fetch after reset at reset vector
// - Mux16: address in the first cycle, then data
// - Mux8: upper shared hold address, lower multiplexed
// - Demux16: shared lines carry only data
// - Demux8: upper lines show internal high byte
// - Latch strobe only on external cycles
// - Latch strobe marks cycle start, valid address
// - Byte-high strobe low for word, high byte on 16-bit bus only
// - Lanes decoded from size, address bit and width
// - Config bit picks byte-high or write-high
module emb_bus #(
  parameter logic [3:0] ADDR_CYC = emb_pkg::EMB_ADDR_CYC,
  parameter logic [3:0] DATA_CYC = emb_pkg::EMB_DATA_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic REQ_IN,
  input wire logic REQ_EXT_IN,
  input wire logic [23:0] REQ_ADDR_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic REQ_WORD_IN,
  input wire logic [15:0] REQ_WDATA_IN,
  input wire logic BUS_WIDE_IN,
  input wire logic BUS_MUX_IN,
  input wire logic [7:0] INT_HIGH_BYTE_IN,
  input wire logic BHE_SELECT_IN,
  input wire logic PORT5_SPECIAL_IN,
  input wire logic [15:0] SHARED_IN,
  output logic REQ_READY_OUT,
  output logic DONE_OUT,
  output logic [15:0] RD_DATA_OUT,
  output logic [15:0] LOW_ADDR_OUT,
  output logic LOW_ADDR_OE_N_OUT,
  output logic [3:0] UPPER_ADDR_OUT,
  output logic UPPER_ADDR_OE_N_OUT,
  output logic [15:0] SHARED_OUT,
  output logic [1:0] SHARED_OE_N_OUT,
  output logic ALE_OUT,
  output logic BYTE_HIGH_ENABLE_N_OUT,
  output logic BYTE_HIGH_ENABLE_OE_N_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  emb_pkg::emb_state_t st_reg;
  emb_pkg::emb_state_t st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic boot_reg;
  logic [19:0] addr_reg;
  logic [15:0] wdata_reg;
  logic wr_reg;
  logic word_reg;
  logic wide_reg;
  logic mux_reg;
  logic done_reg;
  logic [15:0] rd_reg;
  logic [15:0] low_addr_reg;
  logic low_oe_n_reg;
  logic [3:0] upper_reg;
  logic upper_oe_n_reg;
  logic [15:0] shared_reg;
  logic [1:0] shared_oe_n_reg;
  logic ale_reg;
  logic bhe_pin_reg;
  logic bhe_oe_n_reg;
  logic [15:0] shared_sync;

  if (ADDR_CYC == 4'h0 || DATA_CYC == 4'h0) begin : g_chk
    $error("emb_bus phase lengths must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request acceptance
  wire idle = (st_reg == emb_pkg::EMB_ST_IDLE);
  wire taken = idle & REQ_IN & REQ_EXT_IN;
  wire int_taken = idle & REQ_IN & ~REQ_EXT_IN; // No pin activity
  wire cnt_zero = (cnt_reg == 4'h0);
  // Reset vector replaces the first address after reset
  wire [23:0] in_addr = boot_reg ? emb_pkg::EMB_RESET_VECTOR : REQ_ADDR_IN;

  // Current cycle fields: live inputs on the take cycle, else held copies
  wire [19:0] cur_addr = taken ? in_addr[19:0] : addr_reg;
  wire [15:0] cur_wdata = taken ? REQ_WDATA_IN : wdata_reg;
  wire cur_wr = taken ? REQ_WRITE_IN : wr_reg;
  wire cur_word = taken ? REQ_WORD_IN : word_reg;
  wire cur_wide = taken ? BUS_WIDE_IN : wide_reg;
  wire cur_mux = taken ? BUS_MUX_IN : mux_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      emb_pkg::EMB_ST_IDLE: begin
        if (taken) begin
          st_next = emb_pkg::EMB_ST_ADDR;
          cnt_next = ADDR_CYC - 4'h1;
        end
      end
      emb_pkg::EMB_ST_ADDR: begin
        if (cnt_zero) begin
          st_next = emb_pkg::EMB_ST_DATA;
          cnt_next = DATA_CYC - 4'h1;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      emb_pkg::EMB_ST_DATA: begin
        if (cnt_zero && wr_reg) begin
          st_next = emb_pkg::EMB_ST_IDLE;
        end else if (cnt_zero) begin
          st_next = emb_pkg::EMB_ST_SYNC;
          cnt_next = emb_pkg::EMB_SYNC_CYC - 4'h1;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      emb_pkg::EMB_ST_SYNC: begin
        if (cnt_zero) begin
          st_next = emb_pkg::EMB_ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        st_next = emb_pkg::EMB_ST_IDLE;
        cnt_next = emb_pkg::EMB_CNT_RST;
      end
    endcase
  end

  // Completion and read capture points
  wire wr_end = (st_reg == emb_pkg::EMB_ST_DATA) & cnt_zero & wr_reg;
  wire rd_end = (st_reg == emb_pkg::EMB_ST_SYNC) & cnt_zero;
  wire done_next = wr_end | rd_end | int_taken;
  // 8-bit bus returns its byte in the low half
  wire [15:0] rd_next = wide_reg ? shared_sync : {8'h00, shared_sync[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode for the next cycle
  wire n_addr_ph = (st_next == emb_pkg::EMB_ST_ADDR);
  wire n_data_ph = (st_next == emb_pkg::EMB_ST_DATA);
  wire n_busy = n_addr_ph | n_data_ph;
  wire lane_bhe_n;
  wire lane_high;
  wire lane_low;

  emb_lane u_lane (
    .word_in(cur_word),
    .addr0_in(cur_addr[0]),
    .wide_in(cur_wide),
    .byte_high_enable_n_out(lane_bhe_n),
    .high_lane_out(lane_high),
    .low_lane_out(lane_low)
  );

  // 8-bit bus carries an odd byte on the low lane
  wire [7:0] data_lo = (~cur_wide & cur_addr[0]) ? cur_wdata[15:8] : cur_wdata[7:0];
  wire [7:0] data_hi = cur_wdata[15:8];
  // Upper shared byte: address in mux8 and mux16 address phase, internal byte in demux8, else data
  wire hi_is_addr = cur_mux & (n_addr_ph | ~cur_wide);
  wire hi_is_int = ~cur_mux & ~cur_wide;
  wire [7:0] sh_hi_next = hi_is_addr ? cur_addr[15:8] :
                          hi_is_int ? INT_HIGH_BYTE_IN : data_hi;
  wire sh_hi_drive = n_busy & (hi_is_addr | hi_is_int | (cur_wr & lane_high));
  // Lower shared byte: address only in the mux address phase
  wire lo_is_addr = cur_mux & n_addr_ph;
  wire [7:0] sh_lo_next = lo_is_addr ? cur_addr[7:0] : data_lo;
  wire sh_lo_drive = n_busy & (lo_is_addr | (cur_wr & lane_low));

  // Shared strobe pin: byte-high enable or write-high, by configuration
  wire wrh_n = ~(n_data_ph & cur_wr & lane_high);
  wire bhe_n = n_busy ? lane_bhe_n : 1'b1;
  wire bhe_pin_next = BHE_SELECT_IN ? bhe_n : wrh_n;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised shared-line input
  emb_sync #(
    .WIDTH(emb_pkg::EMB_DW)
  ) u_sync (
    .CLOCK_IN(CLOCK_IN),
    .SRST_IN(SRST_IN),
    .d_in(SHARED_IN),
    .q_out(shared_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and request registers
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      st_reg <= emb_pkg::EMB_ST_IDLE;
      cnt_reg <= emb_pkg::EMB_CNT_RST;
      boot_reg <= 1'b1;
      done_reg <= 1'b0;
      rd_reg <= emb_pkg::EMB_DATA_RST;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      boot_reg <= boot_reg & ~(REQ_IN & idle);
      done_reg <= done_next;
      rd_reg <= rd_end ? rd_next : rd_reg;
    end
  end

  // Held copy of the accepted request
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      addr_reg <= '0;
      wdata_reg <= emb_pkg::EMB_DATA_RST;
      {wr_reg, word_reg, wide_reg, mux_reg} <= 4'h0;
    end else begin
      addr_reg <= cur_addr;
      wdata_reg <= cur_wdata;
      {wr_reg, word_reg, wide_reg, mux_reg} <= {cur_wr, cur_word, cur_wide, cur_mux};
    end
  end

  // Pin registers; address lines driven in the address and data phases, released in read sync cycles
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      low_addr_reg <= '0;
      low_oe_n_reg <= 1'b1;
      upper_reg <= 4'h0;
      upper_oe_n_reg <= 1'b1;
      shared_reg <= emb_pkg::EMB_DATA_RST;
      shared_oe_n_reg <= 2'h3;
      ale_reg <= 1'b0;
      bhe_pin_reg <= 1'b1;
      bhe_oe_n_reg <= 1'b1;
    end else begin
      low_addr_reg <= cur_addr[15:0];
      low_oe_n_reg <= ~n_busy;
      upper_reg <= cur_addr[19:16];
      upper_oe_n_reg <= ~n_busy;
      shared_reg <= {sh_hi_next, sh_lo_next};
      shared_oe_n_reg <= {~sh_hi_drive, ~sh_lo_drive};
      ale_reg <= n_addr_ph;
      bhe_pin_reg <= bhe_pin_next;
      bhe_oe_n_reg <= ~PORT5_SPECIAL_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign REQ_READY_OUT = idle;
  assign DONE_OUT = done_reg;
  assign RD_DATA_OUT = rd_reg;
  assign LOW_ADDR_OUT = low_addr_reg;
  assign LOW_ADDR_OE_N_OUT = low_oe_n_reg;
  assign UPPER_ADDR_OUT = upper_reg;
  assign UPPER_ADDR_OE_N_OUT = upper_oe_n_reg;
  assign SHARED_OUT = shared_reg;
  assign SHARED_OE_N_OUT = shared_oe_n_reg;
  assign ALE_OUT = ale_reg;
  assign BYTE_HIGH_ENABLE_N_OUT = bhe_pin_reg;
  assign BYTE_HIGH_ENABLE_OE_N_OUT = bhe_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);

  wire busy = (st_reg == emb_pkg::EMB_ST_ADDR) | (st_reg == emb_pkg::EMB_ST_DATA);

  // Internal access never produces a strobe
  internal_no_ale_a: assert property (int_taken |=> !ALE_OUT [*2])
    else $error("latch strobe on internal access");
  // Strobe only inside the address phase
  ale_in_addr_a: assert property (ALE_OUT |-> st_reg == emb_pkg::EMB_ST_ADDR)
    else $error("latch strobe outside address phase");
  // Strobe starts the cycle with the address on the pins
  ale_start_a: assert property (taken |=> ALE_OUT && !LOW_ADDR_OE_N_OUT &&
    LOW_ADDR_OUT == $past(in_addr[15:0]))
    else $error("cycle start without strobe and address");
  // Low address stays stable while the cycle runs
  low_addr_hold_a: assert property (busy && $past(busy) |->
    $stable(LOW_ADDR_OUT) && !LOW_ADDR_OE_N_OUT)
    else $error("low address changed inside cycle");
  // Upper lines carry bits 16-19 of the accepted address
  upper_addr_a: assert property (taken |=>
    UPPER_ADDR_OUT == $past(in_addr[19:16]) && !UPPER_ADDR_OE_N_OUT)
    else $error("upper address wrong");
  // First fetch after reset, when external, uses the reset vector
  reset_vector_a: assert property (taken && boot_reg |=>
    {UPPER_ADDR_OUT, LOW_ADDR_OUT} == emb_pkg::EMB_RESET_VECTOR[19:0])
    else $error("first fetch not at reset vector");
  // Mux modes: address on all shared lines while the strobe is high
  mux16_phase_a: assert property (ALE_OUT && mux_reg |->
    SHARED_OUT == addr_reg[15:0] && SHARED_OE_N_OUT == 2'h0)
    else $error("mux address phase wrong");
  // Mux8: upper shared lines hold the address all cycle
  mux8_upper_a: assert property (busy && mux_reg && !wide_reg |->
    SHARED_OUT[15:8] == addr_reg[15:8] && !SHARED_OE_N_OUT[1])
    else $error("mux8 upper address wrong");
  // Demux16 write: data from the first cycle on
  demux16_data_a: assert property (busy && !mux_reg && wide_reg && wr_reg &&
    word_reg |-> SHARED_OUT == wdata_reg)
    else $error("demux16 data wrong");
  // Demux8: upper lines copy the internal high byte
  demux8_upper_a: assert property (busy && !mux_reg && !wide_reg |->
    SHARED_OUT[15:8] == $past(INT_HIGH_BYTE_IN))
    else $error("demux8 upper byte wrong");
  // Byte-high strobe on 16-bit word transfers
  bhe_word_a: assert property (busy && wide_reg && word_reg && BHE_SELECT_IN &&
    $past(BHE_SELECT_IN) |-> !BYTE_HIGH_ENABLE_N_OUT)
    else $error("byte-high strobe missing on word");
  // Strobe idle on 8-bit cycles and even bytes
  bhe_idle_a: assert property (busy && (!wide_reg || (!word_reg && !addr_reg[0])) &&
    $past(BHE_SELECT_IN) |-> BYTE_HIGH_ENABLE_N_OUT)
    else $error("byte-high strobe active on low byte");
  // Write-high role never asserts on reads
  wrh_read_a: assert property (busy && !wr_reg && !$past(BHE_SELECT_IN) |->
    BYTE_HIGH_ENABLE_N_OUT)
    else $error("write-high strobe on read");

  // Main scenarios
  mux16_write_c: cover property (taken && REQ_WRITE_IN && BUS_MUX_IN && BUS_WIDE_IN
    ##[1:12] DONE_OUT);
  demux8_read_c: cover property (taken && !REQ_WRITE_IN && !BUS_MUX_IN && !BUS_WIDE_IN
    ##[1:12] DONE_OUT);
  internal_c: cover property (int_taken ##1 DONE_OUT);
  boot_fetch_c: cover property (taken && boot_reg);
endmodule

// *** emb_pkg.sv ***
// Shared constants and types for the external memory bus pin block
package emb_pkg;
  // Address widths: internal, external pins, low address lines; then the data width
  localparam int unsigned EMB_INT_AW = 24;
  localparam int unsigned EMB_EXT_AW = 20;
  localparam int unsigned EMB_LOW_AW = 16;
  localparam int unsigned EMB_DW = 16;
  // Field positions on the external address and the shared lines
  localparam int unsigned EMB_UPPER_LSB = 16;
  localparam int unsigned EMB_HIGH_LANE_LSB = 8;
  // First fetch address after reset; its low 20 bits appear on the pins
  localparam logic [23:0] EMB_RESET_VECTOR = 24'hFF2080;
  // Phase lengths in clock cycles
  localparam logic [3:0] EMB_ADDR_CYC = 4'h1;
  localparam logic [3:0] EMB_DATA_CYC = 4'h2;
  localparam logic [3:0] EMB_SYNC_CYC = 4'h2;
  // Values after reset
  localparam logic [15:0] EMB_DATA_RST = 16'h0000;
  localparam logic [3:0] EMB_CNT_RST = 4'h0;
  // Bus cycle sequencer states, one-hot
  typedef enum logic [3:0] {
    EMB_ST_IDLE = 4'h1,
    EMB_ST_ADDR = 4'h2,
    EMB_ST_DATA = 4'h4,
    EMB_ST_SYNC = 4'h8
  } emb_state_t;
endpackage

// *** emb_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module emb_sync #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Width must be usable
  if (WIDTH < 1) begin : g_chk
    $error("emb_sync width must be at least one");
  end

  // First stage is read only by the second stage
  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule

// *** emb_lane.sv ***
// Byte lane decode from access size, address bit zero and bus width
`timescale 1ns/1ps
module emb_lane (
  input wire logic word_in,
  input wire logic addr0_in,
  input wire logic wide_in,
  output logic byte_high_enable_n_out,
  output logic high_lane_out,
  output logic low_lane_out
);
  // 16-bit bus: word uses both lanes; odd byte high lane; even byte low lane. 8-bit bus: low lane only
  assign high_lane_out = wide_in & (word_in | addr0_in);
  assign low_lane_out = ~wide_in | word_in | ~addr0_in;
  // Strobe low only for 16-bit word or high-byte transfers
  assign byte_high_enable_n_out = ~high_lane_out;
endmodule

// *** emb_mem_model.sv ***
// Behavioural external memory with an address latch on the latch strobe
`timescale 1ns/1ps
module emb_mem_model (
  input wire logic clk_in,
  input wire logic ale_in,
  input wire logic mux_in,
  input wire logic [15:0] low_addr_in,
  input wire logic [3:0] upper_addr_in,
  input wire logic addr_oe_n_in,
  input wire logic [15:0] shared_out_in,
  input wire logic [1:0] shared_oe_n_in,
  output logic [15:0] shared_in_out,
  output logic [19:0] latched_out = 20'h00000
);
  logic [15:0] idle_reg = 16'h3C3C;
  logic [15:0] far_val;
  logic active;
  ////////////////////////////////////////////////////////////////////////
  // Reply only inside a data phase; released lines otherwise keep changing
  assign active = !addr_oe_n_in && !ale_in;
  assign far_val = active ? (latched_out[15:0] ^ 16'h5AC3) : idle_reg;
  // Wire level per lane from the design's enables; the far side drives any released lane
  assign shared_in_out[15:8] = shared_oe_n_in[1] ? far_val[15:8] : shared_out_in[15:8];
  assign shared_in_out[7:0] = shared_oe_n_in[0] ? far_val[7:0] : shared_out_in[7:0];
  ////////////////////////////////////////////////////////////////////////
  // Latch captures the address while the strobe is high
  always @(posedge clk_in) begin
    idle_reg <= ~shared_in_out;
    if (ale_in) begin
      latched_out <= {upper_addr_in, mux_in ? shared_in_out : low_addr_in};
    end
  end
endmodule

// *** tb_emb_bus.sv ***
// Self-checking testbench for the external memory bus pin block
`timescale 1ns/1ps
module tb_emb_bus;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0;
  logic req_ext = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic req_write = 1'b0;
  logic req_word = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic wide = 1'b1;
  logic mux = 1'b1;
  logic [7:0] hib = 8'hC7;
  logic bhe_sel = 1'b1;
  logic p5 = 1'b1;
  logic [15:0] sh_in;
  logic ready, done, low_oe_n, up_oe_n, ale, bhe_n, bhe_oe_n;
  logic [15:0] rd_data, low_addr, sh_out;
  logic [3:0] up_addr;
  logic [1:0] sh_oe_n;
  logic [19:0] latched;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, design and far side
  initial begin
    forever #4 clk = ~clk;
  end
  emb_bus dut (.CLOCK_IN(clk), .SRST_IN(srst), .REQ_IN(req), .REQ_EXT_IN(req_ext),
    .REQ_ADDR_IN(req_addr), .REQ_WRITE_IN(req_write), .REQ_WORD_IN(req_word),
    .REQ_WDATA_IN(wdata), .BUS_WIDE_IN(wide), .BUS_MUX_IN(mux), .INT_HIGH_BYTE_IN(hib),
    .BHE_SELECT_IN(bhe_sel), .PORT5_SPECIAL_IN(p5), .SHARED_IN(sh_in),
    .REQ_READY_OUT(ready), .DONE_OUT(done), .RD_DATA_OUT(rd_data),
    .LOW_ADDR_OUT(low_addr), .LOW_ADDR_OE_N_OUT(low_oe_n), .UPPER_ADDR_OUT(up_addr),
    .UPPER_ADDR_OE_N_OUT(up_oe_n), .SHARED_OUT(sh_out), .SHARED_OE_N_OUT(sh_oe_n),
    .ALE_OUT(ale), .BYTE_HIGH_ENABLE_N_OUT(bhe_n), .BYTE_HIGH_ENABLE_OE_N_OUT(bhe_oe_n));
  emb_mem_model mem (.clk_in(clk), .ale_in(ale), .mux_in(mux), .low_addr_in(low_addr),
    .upper_addr_in(up_addr), .addr_oe_n_in(low_oe_n), .shared_out_in(sh_out),
    .shared_oe_n_in(sh_oe_n), .shared_in_out(sh_in), .latched_out(latched));
  ////////////////////////////////////////////////////////////////////////
  // Comparison and closing report
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // One external access, judged phase by phase; pa is the expected pin address
  task automatic ext_op(input logic w, input logic m, input logic wr, input logic wd,
      input logic [23:0] a, input logic [15:0] d, input logic [19:0] pa);
    logic hi, lo;
    logic [15:0] mask, rexp;
    int k;
    hi = w && (wd || a[0]);
    lo = !w || wd || !a[0];
    mask = {{8{hi}}, {8{lo && w}}};
    rexp = pa[15:0] ^ 16'h5AC3;
    wide = w;
    mux = m;
    req_ext = 1'b1;
    req_write = wr;
    req_word = wd;
    req_addr = a;
    wdata = d;
    req = 1'b1;
    check(24'(ready), 24'h1);
    @(negedge clk);
    req = 1'b0;
    for (k = 1; k < 20; k++) begin
      if (k > 1) @(negedge clk);
      if (done === 1'b1) break;
      check(24'({up_addr, low_addr}), 24'(pa));
      // Address phase raises the strobe; read sync cycles release the address
      check(24'({ale, low_oe_n, up_oe_n, ready}),
        (k == 1) ? 24'h8 : (k > 3) ? 24'h6 : 24'h0);
      if (k == 1 && m) check(24'({sh_oe_n, sh_out}), 24'(pa[15:0]));
      if (k == 2 && m && !w) check(24'({sh_oe_n[1], sh_out[15:8]}), 24'(a[15:8]));
      if (!m && !w && k < 4) check(24'({sh_oe_n[1], sh_out[15:8]}), 24'(hib));
      if (k == 2) begin
        check(24'({bhe_oe_n, bhe_n}), 24'(bhe_sel ? !hi : !(hi && wr)));
      end
      if (k == 2 || (k == 1 && !m)) begin
        if (wr && w) begin
          check(24'({sh_oe_n, sh_out & mask}), 24'({!hi, !lo, d & mask}));
        end else if (wr) begin
          check(24'({sh_oe_n[0], sh_out[7:0]}), 24'(a[0] ? d[15:8] : d[7:0]));
        end else begin
          check(24'(w ? sh_oe_n : {1'b0, sh_oe_n[0]}), w ? 24'h3 : 24'h1);
        end
      end
    end
    // Done follows the last data cycle; reads add two sync cycles
    check(24'({ready, k[3:0]}), 24'({1'b1, wr ? 4'h4 : 4'h6}));
    check(24'(latched), 24'(pa));
    if (!wr) begin
      check(24'(w ? rd_data : {8'h00, rd_data[7:0]}),
        24'(w ? rexp : {8'h00, rexp[7:0]}));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Reset held four cycles, idle pin levels checked, then the first fetch
  task automatic s_reset_vector;
    srst = 1'b1;
    repeat (4) @(negedge clk);
    check(24'({sh_oe_n, low_oe_n, up_oe_n, bhe_oe_n, ale, bhe_n, done, ready}),
      24'h1F5);
    srst = 1'b0;
    ext_op(1'b1, 1'b1, 1'b0, 1'b1, 24'h123456, 16'h0000, 20'hF2080);
  endtask
  task automatic s_internal;
    req_ext = 1'b0;
    req_addr = 24'hFF2100;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    check(24'({done, ale, low_oe_n, sh_oe_n}), 24'h17);
    @(negedge clk);
    check(24'({done, ale}), 24'h0);
  endtask
  task automatic s_modes;
    logic [23:0] a;
    for (int r = 0; r < 2; r++) begin
      bhe_sel = r[0];
      for (int i = 0; i < 4; i++) begin
        hib = 8'h30 + 8'(i);
        for (int j = 0; j < 3; j++) begin
          a = 24'h5B4C60 + 24'(j[0]) + 24'(4 * j);
          ext_op(i[1], i[0], 1'b1, j == 0, a, 16'hA1B2 + 16'(j), a[19:0]);
        end
        ext_op(i[1], i[0], 1'b0, i[1], 24'hE7AD92, 16'h0000, 20'h7AD92);
        ext_op(i[1], i[0], 1'b0, 1'b0, 24'h0C3F05, 16'h0000, 20'hC3F05);
      end
    end
  endtask
  task automatic s_pin_release;
    p5 = 1'b0;
    repeat (2) @(negedge clk);
    check(24'(bhe_oe_n), 24'h1);
    p5 = 1'b1;
    repeat (2) @(negedge clk);
    check(24'(bhe_oe_n), 24'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence and hang guard
  initial begin
    s_reset_vector();
    s_internal();
    s_modes();
    // Reset again mid-run: the next fetch must return to the reset vector
    s_reset_vector();
    s_pin_release();
    summarize();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
endmodule
